// ===== verilog/oad_pkg.sv
// Package of constants and carrier types for the operand address decoder
package oad_pkg;
   // ******************************
   // Field codes
   // ******************************
   localparam logic [1:0] MODE_REG = 2'h3;
   localparam logic [1:0] MODE_NODISP = 2'h0;
   localparam logic [1:0] MODE_DISP8 = 2'h1;
   localparam logic [1:0] MODE_DISP16 = 2'h2;
   localparam logic [2:0] RM_DIRECT = 3'h6;
   localparam logic [2:0] PREFIX_HI = 3'h1;
   localparam logic [2:0] PREFIX_LO = 3'h6;
   localparam logic [7:0] OP_OVF_TRAP = 8'hce;
   localparam logic [7:0] OP_HANDLER_RET = 8'hcf;
   localparam logic [7:0] OP_RANGE_CHECK = 8'h62;
   // ******************************
   // Segment codes
   // ******************************
   localparam logic [1:0] SEG_EXTRA = 2'h0;
   localparam logic [1:0] SEG_CODE = 2'h1;
   localparam logic [1:0] SEG_STACK = 2'h2;
   localparam logic [1:0] SEG_DATA = 2'h3;
   // ******************************
   // Cycle counts
   // ******************************
   localparam logic [7:0] CYC_WORD_EXTRA = 8'h04;
   localparam logic [7:0] CYC_OVF_TAKEN = 8'h30;
   localparam logic [7:0] CYC_OVF_NOT = 8'h04;
   localparam logic [7:0] CYC_RET = 8'h1c;
   localparam logic [7:0] CYC_RANGE_MIN = 8'h21;
   localparam logic [7:0] CYC_RANGE_MAX = 8'h23;
   localparam logic [2:0] CYC_EA = 3'h4;
   localparam logic [7:0] RESET_CYCLES = 8'h00;

   typedef struct packed {
      logic [7:0] opcode;
      logic [1:0] mode;
      logic [2:0] reg_field;
      logic [2:0] rm;
      logic width;
      logic seg_ovr_valid;
      logic [7:0] prefix;
      logic string_dest;
      logic ovf_flag;
      logic range_fail;
   } oad_instr_t;

   typedef struct packed {
      logic [15:0] base_register;
      logic [15:0] source_index;
      logic [15:0] frame_pointer;
      logic [15:0] destination_index;
   } oad_regs_t;

   typedef struct packed {
      logic [15:0] effective_address;
      logic [1:0] segment;
      logic is_register;
      logic [2:0] reg_index;
      logic high_byte;
      logic [1:0] disp_bytes;
   } oad_result_t;
endpackage

// ===== verilog/oad_cycle_count.sv
// Cycle count lookup for trap, return and range-check instructions
`timescale 1ns/1ps
module oad_cycle_count (
   input wire logic [7:0] opcode_in,
   input wire logic ovf_flag_in,
   input wire logic range_fail_in,
   input wire logic word_mem_in,
   output logic [7:0] cycles_out,
   output logic known_out
);
   always_comb begin
      cycles_out = oad_pkg::RESET_CYCLES;
      known_out = 1'b1;
      case (opcode_in)
         oad_pkg::OP_OVF_TRAP: begin
            cycles_out = ovf_flag_in ? oad_pkg::CYC_OVF_TAKEN : oad_pkg::CYC_OVF_NOT;
         end
         oad_pkg::OP_HANDLER_RET: begin
            cycles_out = oad_pkg::CYC_RET;
         end
         oad_pkg::OP_RANGE_CHECK: begin
            // Out-of-range case takes the longer figure
            cycles_out = range_fail_in ? oad_pkg::CYC_RANGE_MAX : oad_pkg::CYC_RANGE_MIN;
         end
         default: begin
            known_out = 1'b0;
         end
      endcase
      if (known_out && word_mem_in && opcode_in == oad_pkg::OP_RANGE_CHECK) begin
         cycles_out = 8'(cycles_out + oad_pkg::CYC_WORD_EXTRA);
      end
   end
endmodule

// ===== verilog/oad_decoder.sv
// Operand address decoder top: mode/rm decode, displacement, segment, cycles
//
// Behaviour
// - word memory transfers add four cycles to range check only
// - overflow trap takes 48 or 4 cycles
// - handler return decoded, takes 28 cycles
// - range check with operand byte, 33-35 cycles
// - mode 11 selects register, no address
// - mode 00 zero displacement, none fetched
// - mode 01 one byte, sign extended
// - mode 10 full sixteen-bit displacement
// - rm code selects address sum terms
// - mode 00 rm 110 is direct address
// - displacement follows second byte, before immediates
// - address computation takes four cycles
// - prefix 001rr110 overrides operand segment
// - register selector indexes words or byte halves
// - frame pointer addressing defaults to stack
// - string destination always extra segment
`timescale 1ns/1ps
module oad_decoder (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic start_in,
   input wire oad_pkg::oad_instr_t instr_in,
   input wire oad_pkg::oad_regs_t regs_in,
   input wire logic byte_valid_in,
   input wire logic [7:0] byte_in,
   output logic busy_out,
   output logic done_out,
   output logic need_byte_out,
   output oad_pkg::oad_result_t result_out,
   output logic [7:0] cycles_out,
   output logic cycles_known_out
);
   // ******************************
   // State
   // ******************************
   typedef enum logic [2:0] {
      OAD_IDLE,
      OAD_DISP_LO,
      OAD_DISP_HI,
      OAD_CALC,
      OAD_DONE
   } oad_phase_t;

   typedef struct packed {
      oad_phase_t phase;
      oad_pkg::oad_instr_t instr;
      oad_pkg::oad_regs_t regs;
      logic [15:0] disp;
      logic [2:0] calc_cnt;
      logic busy;
      logic done;
      logic need_byte;
      oad_pkg::oad_result_t result;
      logic [7:0] cycles;
      logic cycles_known;
   } oad_state_t;

   oad_state_t state_reg;
   oad_state_t state_next;
   logic [7:0] lut_cycles;
   logic lut_known;

   // ******************************
   // Helpers
   // ******************************
   function automatic logic [1:0] disp_count(input logic [1:0] mode, input logic [2:0] rm);
      logic [1:0] n;
      n = 2'h0;
      case (mode)
         oad_pkg::MODE_NODISP: n = (rm == oad_pkg::RM_DIRECT) ? 2'h2 : 2'h0;
         oad_pkg::MODE_DISP8: n = 2'h1;
         oad_pkg::MODE_DISP16: n = 2'h2;
         default: n = 2'h0;
      endcase
      return n;
   endfunction

   function automatic logic [15:0] ea_sum(input oad_pkg::oad_regs_t r, input logic [2:0] rm,
                                          input logic [15:0] d);
      logic [15:0] s;
      s = 16'h0000;
      case (rm)
         3'h0: s = r.base_register + r.source_index;
         3'h1: s = r.base_register + r.destination_index;
         3'h2: s = r.frame_pointer + r.source_index;
         3'h3: s = r.frame_pointer + r.destination_index;
         3'h4: s = r.source_index;
         3'h5: s = r.destination_index;
         3'h6: s = r.frame_pointer;
         default: s = r.base_register;
      endcase
      return 16'(s + d);
   endfunction

   function automatic logic uses_frame(input logic [1:0] mode, input logic [2:0] rm);
      logic f;
      f = (rm == 3'h2) || (rm == 3'h3) || (rm == 3'h6);
      if (mode == oad_pkg::MODE_NODISP && rm == oad_pkg::RM_DIRECT) begin
         f = 1'b0;
      end
      return f;
   endfunction

   oad_cycle_count u_cycles (
      .opcode_in(state_reg.instr.opcode),
      .ovf_flag_in(state_reg.instr.ovf_flag),
      .range_fail_in(state_reg.instr.range_fail),
      .word_mem_in(state_reg.instr.width && state_reg.instr.mode != oad_pkg::MODE_REG),
      .cycles_out(lut_cycles),
      .known_out(lut_known)
   );

   // ******************************
   // Next state
   // ******************************
   always_comb begin
      logic [1:0] seg;
      logic direct;
      seg = oad_pkg::SEG_DATA;
      direct = 1'b0;
      state_next = state_reg;
      state_next.done = 1'b0;
      case (state_reg.phase)
         OAD_IDLE: begin
            if (start_in) begin
               state_next.instr = instr_in;
               state_next.regs = regs_in;
               state_next.disp = 16'h0000;
               state_next.busy = 1'b1;
               state_next.calc_cnt = 3'h0;
               // Displacement bytes are the next ones after the operand byte
               if (disp_count(instr_in.mode, instr_in.rm) != 2'h0) begin
                  state_next.phase = OAD_DISP_LO;
                  state_next.need_byte = 1'b1;
               end else begin
                  state_next.phase = OAD_CALC;
               end
            end
         end
         OAD_DISP_LO: begin
            if (byte_valid_in) begin
               state_next.disp = {{8{byte_in[7]}}, byte_in};
               if (disp_count(state_reg.instr.mode, state_reg.instr.rm) == 2'h2) begin
                  state_next.phase = OAD_DISP_HI;
               end else begin
                  state_next.phase = OAD_CALC;
                  state_next.need_byte = 1'b0;
               end
            end
         end
         OAD_DISP_HI: begin
            if (byte_valid_in) begin
               state_next.disp = {byte_in, state_reg.disp[7:0]};
               state_next.phase = OAD_CALC;
               state_next.need_byte = 1'b0;
            end
         end
         OAD_CALC: begin
            // Fixed latency keeps the pipeline timing mode independent
            state_next.calc_cnt = 3'(state_reg.calc_cnt + 3'h1);
            if (state_reg.calc_cnt == 3'(oad_pkg::CYC_EA - 3'h1)) begin
               direct = state_reg.instr.mode == oad_pkg::MODE_NODISP &&
                        state_reg.instr.rm == oad_pkg::RM_DIRECT;
               state_next.result.is_register = state_reg.instr.mode == oad_pkg::MODE_REG;
               state_next.result.disp_bytes = disp_count(state_reg.instr.mode,
                                                         state_reg.instr.rm);
               if (state_reg.instr.mode == oad_pkg::MODE_REG) begin
                  state_next.result.effective_address = 16'h0000;
                  state_next.result.reg_index = state_reg.instr.width ? state_reg.instr.rm :
                                                {1'b0, state_reg.instr.rm[1:0]};
                  state_next.result.high_byte = !state_reg.instr.width &&
                                                state_reg.instr.rm[2];
               end else begin
                  state_next.result.effective_address = direct ? state_reg.disp :
                     ea_sum(state_reg.regs, state_reg.instr.rm, state_reg.disp);
                  state_next.result.reg_index = state_reg.instr.reg_field;
                  state_next.result.high_byte = 1'b0;
               end
               if (uses_frame(state_reg.instr.mode, state_reg.instr.rm)) begin
                  seg = oad_pkg::SEG_STACK;
               end
               if (state_reg.instr.seg_ovr_valid &&
                   state_reg.instr.prefix[7:5] == oad_pkg::PREFIX_HI &&
                   state_reg.instr.prefix[2:0] == oad_pkg::PREFIX_LO) begin
                  seg = state_reg.instr.prefix[4:3];
               end
               if (state_reg.instr.string_dest) begin
                  seg = oad_pkg::SEG_EXTRA;
               end
               state_next.result.segment = seg;
               state_next.cycles = lut_cycles;
               state_next.cycles_known = lut_known;
               state_next.phase = OAD_DONE;
            end
         end
         OAD_DONE: begin
            state_next.done = 1'b1;
            state_next.busy = 1'b0;
            state_next.phase = OAD_IDLE;
         end
         default: begin
            state_next.phase = OAD_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign busy_out = state_reg.busy;
   assign done_out = state_reg.done;
   assign need_byte_out = state_reg.need_byte;
   assign result_out = state_reg.result;
   assign cycles_out = state_reg.cycles;
   assign cycles_known_out = state_reg.cycles_known;

   // ******************************
   // Checks
   // ******************************
   sequence s_calc_four;
      (state_reg.phase == OAD_CALC) [*4];
   endsequence

   a_calc_four_cycles: assert property (@(posedge clk_in) disable iff (rst_in)
      $rose(state_reg.phase == OAD_CALC) |-> s_calc_four ##1 state_reg.phase == OAD_DONE)
      else $error("address calc not four cycles");
   a_string_dest_extra: assert property (@(posedge clk_in) disable iff (rst_in)
      state_reg.phase == OAD_DONE && state_reg.instr.string_dest |->
      result_out.segment == oad_pkg::SEG_EXTRA)
      else $error("string destination not extra segment");
   a_register_mode: assert property (@(posedge clk_in) disable iff (rst_in)
      state_reg.phase == OAD_DONE && state_reg.instr.mode == oad_pkg::MODE_REG |->
      result_out.is_register && result_out.disp_bytes == 2'h0)
      else $error("register mode computed address");
   a_direct_address: assert property (@(posedge clk_in) disable iff (rst_in)
      state_reg.phase == OAD_DONE && state_reg.instr.mode == oad_pkg::MODE_NODISP &&
      state_reg.instr.rm == oad_pkg::RM_DIRECT |->
      result_out.effective_address == state_reg.disp && result_out.disp_bytes == 2'h2)
      else $error("direct address wrong");
   a_disp8_sign: assert property (@(posedge clk_in) disable iff (rst_in)
      state_reg.phase == OAD_DISP_LO && byte_valid_in &&
      state_reg.instr.mode == oad_pkg::MODE_DISP8 |=>
      state_reg.disp == {{8{$past(byte_in[7])}}, $past(byte_in)} && state_reg.phase == OAD_CALC)
      else $error("short displacement not sign extended");
   a_disp16_pair: assert property (@(posedge clk_in) disable iff (rst_in)
      state_reg.phase == OAD_DISP_HI && byte_valid_in |=>
      state_reg.disp[15:8] == $past(byte_in) && state_reg.phase == OAD_CALC)
      else $error("high displacement byte lost");
   a_no_disp_mode0: assert property (@(posedge clk_in) disable iff (rst_in)
      state_reg.phase == OAD_IDLE && start_in && instr_in.mode == oad_pkg::MODE_NODISP &&
      instr_in.rm != oad_pkg::RM_DIRECT |=> state_reg.phase == OAD_CALC && state_reg.disp == 0)
      else $error("mode zero fetched displacement");
   a_frame_stack_seg: assert property (@(posedge clk_in) disable iff (rst_in)
      state_reg.phase == OAD_DONE && !state_reg.instr.string_dest &&
      !state_reg.instr.seg_ovr_valid && uses_frame(state_reg.instr.mode, state_reg.instr.rm) |->
      result_out.segment == oad_pkg::SEG_STACK)
      else $error("frame pointer not stack segment");
   a_return_cycles: assert property (@(posedge clk_in) disable iff (rst_in)
      state_reg.phase == OAD_DONE && state_reg.instr.opcode == oad_pkg::OP_HANDLER_RET |->
      cycles_out == 8'h1c && cycles_known_out)
      else $error("return cycle count wrong");
   a_trap_cycles: assert property (@(posedge clk_in) disable iff (rst_in)
      state_reg.phase == OAD_DONE && state_reg.instr.opcode == oad_pkg::OP_OVF_TRAP |->
      cycles_out == (state_reg.instr.ovf_flag ? 8'h30 : 8'h04))
      else $error("overflow trap cycle count wrong");
   a_override_seg: assert property (@(posedge clk_in) disable iff (rst_in)
      state_reg.phase == OAD_DONE && !state_reg.instr.string_dest &&
      state_reg.instr.seg_ovr_valid && state_reg.instr.prefix[7:5] == 3'h1 &&
      state_reg.instr.prefix[2:0] == 3'h6 |-> result_out.segment == state_reg.instr.prefix[4:3])
      else $error("segment override ignored");

   // ******************************
   // Checks on fetch and handshake
   // ******************************
   sequence s_lo_taken;
      state_reg.phase == OAD_DISP_LO && byte_valid_in;
   endsequence

   sequence s_hi_pending;
      state_reg.phase == OAD_DISP_HI && need_byte_out;
   endsequence

   a_disp_first: assert property (@(posedge clk_in) disable iff (rst_in)
      state_reg.phase == OAD_IDLE && start_in &&
      disp_count(instr_in.mode, instr_in.rm) != 2'h0 |=>
      state_reg.phase == OAD_DISP_LO && need_byte_out)
      else $error("displacement not fetched first");
   a_two_disp_bytes: assert property (@(posedge clk_in) disable iff (rst_in)
      s_lo_taken ##0 state_reg.instr.mode == oad_pkg::MODE_DISP16 |=> s_hi_pending)
      else $error("second displacement byte not awaited");
   a_one_disp_byte: assert property (@(posedge clk_in) disable iff (rst_in)
      s_lo_taken ##0 state_reg.instr.mode == oad_pkg::MODE_DISP8 |=>
      !need_byte_out && state_reg.phase == OAD_CALC)
      else $error("short displacement awaited a high byte");
   a_direct_two_bytes: assert property (@(posedge clk_in) disable iff (rst_in)
      s_lo_taken ##0 state_reg.instr.mode == oad_pkg::MODE_NODISP |=> s_hi_pending)
      else $error("direct address missing high byte");
   // Next start may land right after done, so busy is only checked in the done cycle
   a_done_pulse: assert property (@(posedge clk_in) disable iff (rst_in)
      done_out |-> !busy_out ##1 !done_out)
      else $error("done held longer than one cycle");
   // Captured operands hold from start to done, so late starts are dropped
   a_start_refused: assert property (@(posedge clk_in) disable iff (rst_in)
      state_reg.phase != OAD_IDLE |=> $stable(state_reg.instr) && $stable(state_reg.regs))
      else $error("start taken while busy");

   // ******************************
   // Checks on counts, sums, register selects and default segment
   // ******************************
   a_word_extra: assert property (@(posedge clk_in) disable iff (rst_in)
      state_reg.phase == OAD_DONE && state_reg.instr.opcode == oad_pkg::OP_RANGE_CHECK &&
      state_reg.instr.width && state_reg.instr.mode != oad_pkg::MODE_REG |->
      cycles_out == 8'((state_reg.instr.range_fail ? oad_pkg::CYC_RANGE_MAX :
                        oad_pkg::CYC_RANGE_MIN) + oad_pkg::CYC_WORD_EXTRA))
      else $error("word operand missing extra cycles");
   a_range_cycles: assert property (@(posedge clk_in) disable iff (rst_in)
      state_reg.phase == OAD_DONE && state_reg.instr.opcode == oad_pkg::OP_RANGE_CHECK &&
      !(state_reg.instr.width && state_reg.instr.mode != oad_pkg::MODE_REG) |->
      cycles_known_out && cycles_out >= oad_pkg::CYC_RANGE_MIN &&
      cycles_out <= oad_pkg::CYC_RANGE_MAX)
      else $error("range check cycle count out of bounds");
   a_ea_base_src: assert property (@(posedge clk_in) disable iff (rst_in)
      state_reg.phase == OAD_DONE && state_reg.instr.mode != oad_pkg::MODE_REG &&
      state_reg.instr.rm == 3'h0 |-> result_out.effective_address ==
      16'(state_reg.regs.base_register + state_reg.regs.source_index + state_reg.disp))
      else $error("base plus source index sum wrong");
   a_ea_frame_dest: assert property (@(posedge clk_in) disable iff (rst_in)
      state_reg.phase == OAD_DONE && state_reg.instr.mode != oad_pkg::MODE_REG &&
      state_reg.instr.rm == 3'h3 |-> result_out.effective_address ==
      16'(state_reg.regs.frame_pointer + state_reg.regs.destination_index + state_reg.disp))
      else $error("frame plus destination index sum wrong");
   a_ea_dest_only: assert property (@(posedge clk_in) disable iff (rst_in)
      state_reg.phase == OAD_DONE && state_reg.instr.mode != oad_pkg::MODE_REG &&
      state_reg.instr.rm == 3'h5 |-> result_out.effective_address ==
      16'(state_reg.regs.destination_index + state_reg.disp))
      else $error("destination index sum wrong");
   a_word_reg_select: assert property (@(posedge clk_in) disable iff (rst_in)
      state_reg.phase == OAD_DONE && state_reg.instr.mode == oad_pkg::MODE_REG &&
      state_reg.instr.width |-> result_out.reg_index == state_reg.instr.rm &&
      !result_out.high_byte)
      else $error("word register select wrong");
   a_byte_reg_select: assert property (@(posedge clk_in) disable iff (rst_in)
      state_reg.phase == OAD_DONE && state_reg.instr.mode == oad_pkg::MODE_REG &&
      !state_reg.instr.width |-> !result_out.reg_index[2] &&
      result_out.reg_index[1:0] == state_reg.instr.rm[1:0] &&
      result_out.high_byte == state_reg.instr.rm[2])
      else $error("byte register half wrong");
   a_default_data_seg: assert property (@(posedge clk_in) disable iff (rst_in)
      state_reg.phase == OAD_DONE && !state_reg.instr.string_dest &&
      !state_reg.instr.seg_ovr_valid &&
      !uses_frame(state_reg.instr.mode, state_reg.instr.rm) |->
      result_out.segment == oad_pkg::SEG_DATA)
      else $error("default segment not data");
endmodule

// ===== verif/operand_address_decoder_tb.sv
// Self-checking testbench for the operand address decoder
`timescale 1ns/1ps
module operand_address_decoder_tb;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic start_in = 1'b0;
   oad_pkg::oad_instr_t instr_in = '0;
   oad_pkg::oad_regs_t regs_in = '0;
   logic byte_valid_in = 1'b0;
   logic [7:0] byte_in = 8'h00;
   logic busy_out;
   logic done_out;
   logic need_byte_out;
   oad_pkg::oad_result_t result_out;
   logic [7:0] cycles_out;
   logic cycles_known_out;
   int failures = 0;
   int comparisons = 0;
   logic [7:0] ops [3] = '{8'hce, 8'hcf, 8'h62};

   always #2 clk_in = ~clk_in;

   oad_decoder i_dut (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .start_in(start_in),
      .instr_in(instr_in),
      .regs_in(regs_in),
      .byte_valid_in(byte_valid_in),
      .byte_in(byte_in),
      .busy_out(busy_out),
      .done_out(done_out),
      .need_byte_out(need_byte_out),
      .result_out(result_out),
      .cycles_out(cycles_out),
      .cycles_known_out(cycles_known_out)
   );

   // ******************************
   // Reporting
   // ******************************
   task automatic finish_test();
      $display("Counts: %0d comparisons, %0d failures", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("FAIL at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // ******************************
   // Expected values
   // ******************************
   function automatic oad_pkg::oad_result_t exp_res(input oad_pkg::oad_instr_t i,
         input oad_pkg::oad_regs_t r, input logic [7:0] lo, input logic [7:0] hi);
      oad_pkg::oad_result_t e;
      logic [15:0] disp;
      logic direct;
      e = '0;
      direct = (i.mode == 2'h0) && (i.rm == 3'h6);
      disp = (i.mode == 2'h1) ? {{8{lo[7]}}, lo} : ((i.mode == 2'h2) ? {hi, lo} : 16'h0000);
      e.disp_bytes = (i.mode == 2'h1) ? 2'h1 : ((i.mode == 2'h2 || direct) ? 2'h2 : 2'h0);
      case (i.rm)
         3'h0: e.effective_address = r.base_register + r.source_index + disp;
         3'h1: e.effective_address = r.base_register + r.destination_index + disp;
         3'h2: e.effective_address = r.frame_pointer + r.source_index + disp;
         3'h3: e.effective_address = r.frame_pointer + r.destination_index + disp;
         3'h4: e.effective_address = r.source_index + disp;
         3'h5: e.effective_address = r.destination_index + disp;
         3'h6: e.effective_address = direct ? {hi, lo} : r.frame_pointer + disp;
         default: e.effective_address = r.base_register + disp;
      endcase
      // Destination of a string op cannot be overridden
      if (i.string_dest) begin
         e.segment = 2'h0;
      end else if (i.seg_ovr_valid && i.prefix[7:5] == 3'h1 && i.prefix[2:0] == 3'h6) begin
         e.segment = i.prefix[4:3];
      end else if (i.rm == 3'h2 || i.rm == 3'h3 || (i.rm == 3'h6 && !direct)) begin
         e.segment = 2'h2;
      end else begin
         e.segment = 2'h3;
      end
      e.reg_index = i.reg_field;
      if (i.mode == 2'h3) begin
         e.effective_address = 16'h0000;
         e.disp_bytes = 2'h0;
         e.is_register = 1'b1;
         e.reg_index = i.width ? i.rm : {1'b0, i.rm[1:0]};
         e.high_byte = !i.width && i.rm[2];
      end
      return e;
   endfunction

   function automatic logic [8:0] exp_cyc(input oad_pkg::oad_instr_t i);
      logic [7:0] w;
      w = (i.width && i.mode != 2'h3) ? 8'h04 : 8'h00;
      case (i.opcode)
         8'hce: return {1'b1, i.ovf_flag ? 8'h30 : 8'h04};
         8'hcf: return {1'b1, 8'h1c};
         8'h62: return {1'b1, (i.range_fail ? 8'h23 : 8'h21) + w};
         default: return 9'h000;
      endcase
   endfunction

   // ******************************
   // One decode, entered just after an edge
   // ******************************
   task automatic run_one(input oad_pkg::oad_instr_t ins, input oad_pkg::oad_regs_t rg,
         input logic [7:0] lo, input logic [7:0] hi, input int stall);
      oad_pkg::oad_result_t e;
      logic [8:0] c;
      logic [7:0] q [$];
      int n;
      e = exp_res(ins, rg, lo, hi);
      c = exp_cyc(ins);
      if (e.disp_bytes != 2'h0) q.push_back(lo);
      if (e.disp_bytes == 2'h2) q.push_back(hi);
      start_in = 1'b1;
      instr_in = ins;
      regs_in = rg;
      @(posedge clk_in);
      #1;
      start_in = 1'b0;
      // Scramble inputs to show they were captured at start
      instr_in = $bits(instr_in)'($urandom());
      regs_in = {$urandom(), $urandom()};
      chk({15'h0000, busy_out}, 16'h0001);
      if (q.size() > 0) begin
         repeat (stall) begin
            @(posedge clk_in);
            #1;
         end
      end
      n = 0;
      while (q.size() > 0 && n < 40) begin
         byte_valid_in = 1'b1;
         byte_in = q[0];
         if (need_byte_out === 1'b1) q.delete(0);
         @(posedge clk_in);
         #1;
         n++;
      end
      byte_valid_in = 1'b0;
      byte_in = ~byte_in;
      n = 0;
      while (done_out !== 1'b1 && n < 20) begin
         @(posedge clk_in);
         #1;
         n++;
         // Stray starts while busy must be ignored
         start_in = (done_out !== 1'b1) && ($urandom_range(1) == 1);
      end
      chk(16'(n), 16'h0005);
      chk(result_out.effective_address, e.effective_address);
      chk({14'h0000, result_out.disp_bytes}, {14'h0000, e.disp_bytes});
      chk({15'h0000, result_out.is_register}, {15'h0000, e.is_register});
      chk({13'h0000, result_out.reg_index}, {13'h0000, e.reg_index});
      if (ins.mode == 2'h3) begin
         chk({15'h0000, result_out.high_byte}, {15'h0000, e.high_byte});
      end else begin
         chk({14'h0000, result_out.segment}, {14'h0000, e.segment});
      end
      chk({7'h00, cycles_known_out, cycles_out}, {7'h00, c});
      @(posedge clk_in);
      #1;
      chk({14'h0000, busy_out, done_out}, 16'h0000);
   endtask

   // ******************************
   // Main sequence
   // ******************************
   initial begin
      oad_pkg::oad_instr_t ins;
      void'($urandom(32'h7192));
      repeat (6) @(posedge clk_in);
      #1;
      rst_in = 1'b0;
      chk({13'h0000, busy_out, done_out, need_byte_out}, 16'h0000);
      chk({7'h00, cycles_known_out, cycles_out}, 16'h0000);
      $display("Test reset ended");
      // Every mode and rm code, negative short displacement, wrapping sums
      for (int k = 0; k < 32; k++) begin
         ins = '0;
         ins.mode = k[4:3];
         ins.rm = k[2:0];
         ins.width = 1'b1;
         ins.reg_field = 3'h5;
         ins.opcode = 8'h62;
         run_one(ins, 64'hf0f0_1234_8001_7ffe, 8'h80, 8'hc3, k % 3);
      end
      $display("Test mode table ended");
      for (int k = 0; k < 300; k++) begin
         ins = $bits(ins)'($urandom());
         if (k % 4 != 3) ins.opcode = ops[k % 3];
         ins.string_dest = ($urandom_range(3) == 0);
         // Every fifth keeps a junk prefix byte, which must not override
         if (ins.seg_ovr_valid && k % 5 != 0) ins.prefix = {3'h1, ins.prefix[4:3], 3'h6};
         run_one(ins, {$urandom(), $urandom()}, 8'($urandom()), 8'($urandom()),
                 $urandom_range(2));
      end
      $display("Test random decodes ended");
      finish_test();
   end

   initial begin
      #60000;
      failures++;
      $display("Watchdog expired");
      finish_test();
   end
endmodule
